// file: include/charger_irq_pkg.sv
/*
  Register map, field positions and carrier types for the charger
  status and interrupt register block.
  Assumes an 8-bit register port driven by the serial bus front end.
*/
package charger_irq_pkg;

  localparam logic [7:0] ADDR_LIVE_STATUS  = 8'h78;
  localparam logic [7:0] ADDR_EVENT_EN     = 8'h79;
  localparam logic [7:0] ADDR_PHASE_INPUT  = 8'h7a;

  // Live status field positions
  localparam int GRP_LSB         = 4;
  localparam int TIMER_EXP_BIT   = 3;
  localparam int TEMP_OK_BIT     = 2;
  localparam int INPUT_VALID_BIT = 1;
  localparam int EOC_FLAG_BIT    = 0;

  // Phase and input register field positions
  localparam int PHASE_LSB       = 4;
  localparam int AUX_LEVEL_BIT   = 1;

  // Group indices; group g owns enable bits g+4 (first event) and g (second)
  localparam int NUM_GROUPS      = 4;
  localparam int GRP_TIMEOUT     = 3;
  localparam int GRP_TEMP        = 2;
  localparam int GRP_INPUT       = 1;
  localparam int GRP_EOC         = 0;

  localparam logic [7:0] EVENT_EN_RESET   = 8'h00;
  localparam logic [3:0] GRP_EN_RESET     = 4'h0;
  localparam logic [7:0] RDATA_RESET      = 8'h00;

  // Live inputs from the analog charger and its state machine
  typedef struct packed {
    logic       battery_temp_ok;
    logic       input_valid;
    logic       eoc_state;
    logic [1:0] charge_phase;
    logic       aux_supply_sense;
    logic       precondition_expired;
    logic       total_expired;
  } charger_live_t;

  // Register port request from the serial bus front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : charger_irq_pkg

// file: rtl/charger_status_interrupt_regs.sv
/*
  Charger status and interrupt control registers with open-drain
  interrupt request output.
  Assumes the serial bus slave presents one-cycle read/write strobes
  synchronous to clk_sys, and that all charger inputs are synchronous.
*/
`timescale 1ns/1ps
module charger_status_interrupt_regs
  import charger_irq_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire charger_live_t live,
  input  wire reg_req_t      req,
  output logic [7:0]         rdata,
  output logic               rvalid,
  output logic               interrupt_out_low,
  output logic               interrupt_oe_n
);

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction : hit

  // Event and enable state
  logic [7:0]            event_en;
  logic [7:0]            next_event_en;
  logic [3:0]            grp_en;
  logic [3:0]            next_grp_en;
  logic [3:0]            pending;
  logic [3:0]            next_pending;
  charger_live_t         live_q;
  charger_live_t         next_live_q;

  // Read port state
  logic [7:0]            next_rdata;
  logic                  next_rvalid;
  logic                  next_oe_n;

  logic [3:0]            ev_first;
  logic [3:0]            ev_second;
  logic [3:0]            ev_fire;
  logic                  chg_in_range;
  logic                  stat_read;
  logic [7:0]            live_word;
  logic [7:0]            phase_word;

  assign chg_in_range = live.input_valid;
  assign stat_read    = req.rd && hit(req, ADDR_LIVE_STATUS);

  // Edges of the live inputs, seen in the same cycle as the change
  always_comb begin
    ev_first  = 4'h0;
    ev_second = 4'h0;
    ev_first[GRP_TIMEOUT]  = live.total_expired & ~live_q.total_expired;
    ev_second[GRP_TIMEOUT] = live.precondition_expired & ~live_q.precondition_expired;
    ev_first[GRP_TEMP]     = live.battery_temp_ok & ~live_q.battery_temp_ok;
    ev_second[GRP_TEMP]    = ~live.battery_temp_ok & live_q.battery_temp_ok;
    ev_first[GRP_INPUT]    = live.input_valid & ~live_q.input_valid;
    ev_second[GRP_INPUT]   = ~live.input_valid & live_q.input_valid;
    ev_first[GRP_EOC]      = live.eoc_state & ~live_q.eoc_state;
    ev_second[GRP_EOC]     = ~live.eoc_state & live_q.eoc_state;
    // temperature and end-of-charge ignored out of range
    if (!chg_in_range) begin
      ev_first[GRP_TEMP]   = 1'b0;
      ev_second[GRP_TEMP]  = 1'b0;
      ev_first[GRP_EOC]    = 1'b0;
      ev_second[GRP_EOC]   = 1'b0;
    end
  end

  // Each event needs its own enable bit and the enable bit of its group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    assign ev_fire[g] = grp_en[g] &
                        ((ev_first[g] & event_en[g + GRP_LSB]) |
                         (ev_second[g] & event_en[g]));
  end

  always_comb begin
    next_live_q   = live;
    next_event_en = event_en;
    next_grp_en   = grp_en;
    next_pending  = pending;
    if (req.wr && hit(req, ADDR_EVENT_EN)) begin
      next_event_en = req.wdata;
    end
    // upper bits written as group enables
    if (req.wr && hit(req, ADDR_LIVE_STATUS)) begin
      next_grp_en = req.wdata[GRP_LSB +: NUM_GROUPS];
    end
    // clear on status read, new event wins
    if (stat_read) begin
      next_pending = 4'h0;
    end
    next_pending = next_pending | ev_fire;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      live_q   <= '0;
      event_en <= EVENT_EN_RESET;
      grp_en   <= GRP_EN_RESET;
      pending  <= 4'h0;
    end else begin
      live_q   <= next_live_q;
      event_en <= next_event_en;
      grp_en   <= next_grp_en;
      pending  <= next_pending;
    end
  end

  // Read words built from the present live inputs and the pending bits
  always_comb begin
    live_word = 8'h00;
    // upper bits read as pending status
    live_word[GRP_LSB +: NUM_GROUPS] = pending;
    live_word[TIMER_EXP_BIT]   = live.precondition_expired | live.total_expired;
    live_word[TEMP_OK_BIT]     = live.battery_temp_ok;
    live_word[INPUT_VALID_BIT] = live.input_valid;
    live_word[EOC_FLAG_BIT]    = live.eoc_state;
    phase_word = 8'h00;
    phase_word[PHASE_LSB +: 2] = live.charge_phase;
    phase_word[AUX_LEVEL_BIT]  = live.aux_supply_sense;
  end

  always_comb begin
    next_rvalid = req.rd;
    next_rdata  = rdata;
    if (req.rd) begin
      if (hit(req, ADDR_LIVE_STATUS)) begin
        next_rdata = live_word;
      end else if (hit(req, ADDR_EVENT_EN)) begin
        next_rdata = event_en;
      end else if (hit(req, ADDR_PHASE_INPUT)) begin
        next_rdata = phase_word;
      end else begin
        // Unmapped addresses answer zero
        next_rdata = 8'h00;
      end
    end
    // drive low while any enabled group pending
    // held until the pending bits or their group enables clear
    next_oe_n = ~(|(next_pending & next_grp_en));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata             <= RDATA_RESET;
      rvalid            <= 1'b0;
      interrupt_oe_n    <= 1'b1;
      interrupt_out_low <= 1'b0;
    end else begin
      rdata             <= next_rdata;
      rvalid            <= next_rvalid;
      interrupt_oe_n    <= next_oe_n;
      // Open drain only ever pulls low
      interrupt_out_low <= 1'b0;
    end
  end

endmodule : charger_status_interrupt_regs

// file: tb/charger_irq_checker.sv
/* Assertions on the charger register block ports.
   Assumes one clock and the bind at the foot. */
`timescale 1ns/1ps
module charger_irq_checker
  import charger_irq_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire charger_live_t live,
  input wire reg_req_t      req,
  input wire logic [7:0]    rdata,
  input wire logic          rvalid,
  input wire logic          interrupt_out_low,
  input wire logic          interrupt_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire       rd78 = req.rd && req.addr == ADDR_LIVE_STATUS;
  wire       rd7a = req.rd && req.addr == ADDR_PHASE_INPUT;
  wire       wr79 = req.wr && req.addr == ADDR_EVENT_EN;
  wire       rd79 = req.rd && req.addr == ADDR_EVENT_EN;
  wire [3:0] lo   = {live.precondition_expired | live.total_expired, live.battery_temp_ok, live.input_valid,
                     live.eoc_state};
  wire [7:0] ph   = {2'h0, live.charge_phase, 2'h0, live.aux_supply_sense, 1'h0};
  property p_ans; req.rd |=> rvalid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_noans; !req.rd |=> !rvalid; endproperty
  a_noans: assert property (p_noans) else $error("stray rvalid");
  property p_live; rd78 |=> rdata[3:0] == $past(lo); endproperty
  a_live: assert property (p_live) else $error("live bits");
  property p_phase; rd7a |=> rdata == $past(ph); endproperty
  a_phase: assert property (p_phase) else $error("phase reg");
  property p_low; interrupt_out_low == 1'h0; endproperty
  a_low: assert property (p_low) else $error("pin level");
  property p_rel; rd78 && live == $past(live) |=> interrupt_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_quiet; interrupt_oe_n && !req.wr && live == $past(live) |=> interrupt_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("irq without event");
  property p_en; wr79 ##2 rd79 |=> rdata == $past(req.wdata, 3); endproperty
  a_en: assert property (p_en) else $error("enable readback");
  c_irq: cover property (rd78 && !interrupt_oe_n);
  c_fall: cover property ($fell(interrupt_oe_n));
  c_ph: cover property (rd7a);
endmodule : charger_irq_checker

bind charger_status_interrupt_regs charger_irq_checker i_chk (.clk_sys(clk_sys), .rst(rst), .live(live),
  .req(req), .rdata(rdata), .rvalid(rvalid), .interrupt_out_low(interrupt_out_low), .interrupt_oe_n(interrupt_oe_n));

// file: tb/charger_host.sv
/* Host model: one-cycle register strobes.
   Assumes the bench calls wr and rd by hierarchy. */
`timescale 1ns/1ps
module charger_host
  import charger_irq_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output reg_req_t        req
);
  initial req = '{1'h0, 1'h0, 8'h00, 8'h00};
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{1'h0 ^ 1'h1, 1'h0, a, d};
    @(posedge clk_sys);
    #1 req = '{1'h0, 1'h0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    @(posedge clk_sys);
    #1 req = '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk_sys);
    #1 req = '{1'h0, 1'h0, ~a, 8'hff};
    i = 0;
    while (rvalid !== 1'h1 && i < 4) begin
      @(posedge clk_sys);
      #1 i++;
    end
    ok = rvalid === 1'h1;
    d = rdata;
  endtask : rd
endmodule : charger_host

// file: tb/tb.sv
/* Top bench: drives live inputs, host model makes register traffic.
   Assumes the bound checker watches the ports. */
`timescale 1ns/1ps
module tb
  import charger_irq_pkg::*;
;
  logic          clk_sys, rst, rvalid, out_low, oe_n, ok, e;
  logic [7:0]    rdata, d;
  charger_live_t live;
  reg_req_t      req;
  int            n_tests = 0, n_mismatch = 0;
  charger_host i_host (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid), .req(req));
  charger_status_interrupt_regs i_dut (.clk_sys(clk_sys), .rst(rst), .live(live), .req(req), .rdata(rdata),
    .rvalid(rvalid), .interrupt_out_low(out_low), .interrupt_oe_n(oe_n));
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string s, logic [7:0] x, logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic rd(logic [7:0] a);
    i_host.rd(a, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    if (ok !== 1'h1) tally_and_finish();
  endtask : rd
  task automatic put(int g, int s, logic v);
    case (g)
      3: if (s == 1) live.precondition_expired = v; else live.total_expired = v;
      2: live.battery_temp_ok = v;
      1: live.input_valid = v;
      default: live.eoc_state = v;
    endcase
  endtask : put
  initial begin
    rst = 1'h1;
    live = 8'h40;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'h0;
    chk("oe_n", 8'h01, {7'h00, oe_n});
    chk("pin level", 8'h00, {7'h00, out_low});
    rd(ADDR_EVENT_EN);
    chk("en reset", EVENT_EN_RESET, d);
    rd(8'h55);
    chk("unmapped", 8'h00, d);
    $display("reset test done");
    i_host.wr(ADDR_PHASE_INPUT, 8'hff);
    for (int p = 0; p < 4; p++) begin
      // One assignment per step keeps the live word glitch free
      live = charger_live_t'({1'b0, 1'b1, 1'b0, p[1:0], p[0], 2'b00});
      rd(ADDR_PHASE_INPUT);
      chk("phase", {2'h0, p[1:0], 2'h0, p[0], 1'h0}, d);
    end
    $display("phase test done");
    for (int g = 0; g < 4; g++)
      for (int s = 0; s < 2; s++) begin
        live = (g == 1) ? 8'h00 : 8'h40;
        i_host.wr(ADDR_LIVE_STATUS, 8'h10 << g);
        i_host.wr(ADDR_EVENT_EN, s ? 8'h01 << g : 8'h10 << g);
        rd(ADDR_EVENT_EN);
        chk("en", s ? 8'h01 << g : 8'h10 << g, d);
        rd(ADDR_LIVE_STATUS);
        for (int v = 1; v >= 0; v--) begin
          @(posedge clk_sys);
          #1 put(g, s, v[0]);
          @(posedge clk_sys);
          #1 e = (g == 3 || s == 0) ? v[0] : !v[0];
          chk("oe_n", {7'h00, !e}, {7'h00, oe_n});
          rd(ADDR_LIVE_STATUS);
          chk("pending", {7'h00, e}, {7'h00, d[4+g]});
          chk("oe_n after read", 8'h01, {7'h00, oe_n});
        end
      end
    $display("event test done");
    live = 8'h00;
    i_host.wr(ADDR_LIVE_STATUS, 8'h50);
    i_host.wr(ADDR_EVENT_EN, 8'h55);
    rd(ADDR_LIVE_STATUS);
    @(posedge clk_sys);
    #1 live = 8'ha0;
    @(posedge clk_sys);
    #1 chk("oe_n invalid input", 8'h01, {7'h00, oe_n});
    rd(ADDR_LIVE_STATUS);
    chk("status", 8'h05, d);
    $display("input invalid test done");
    tally_and_finish();
  end
endmodule : tb
